/* File: inc/pse_params.svh */
// Offsets, field positions, reset values, codes and counts for the precise sample engine
`ifndef PSE_PARAMS_SVH
`define PSE_PARAMS_SVH
// Register byte offsets
`define PSE_OFF_CTRL 8'h00
`define PSE_OFF_THRESH 8'h04
`define PSE_OFF_COUNT 8'h08
`define PSE_OFF_SHADOW 8'h0C
`define PSE_OFF_STATUS 8'h10
`define PSE_OFF_NEWEST 8'h14
`define PSE_OFF_REC_BIT 6
// Control fields
`define PSE_CTRL_LD_EN 0
`define PSE_CTRL_BR_EN 1
`define PSE_CTRL_MISP 2
`define PSE_CTRL_TYPE_LO 4
`define PSE_CTRL_W 6
// Branch type selections
`define PSE_BT_ALL 2'h0
`define PSE_BT_CALL 2'h1
`define PSE_BT_COND 2'h2
// Status fields
`define PSE_ST_ARMED 0
`define PSE_ST_SHADOW 1
`define PSE_ST_FROZEN 2
`define PSE_ST_WRITING 3
`define PSE_ST_SLOT_LO 8
`define PSE_ST_TOTAL_LO 16
// Reset values
`define PSE_CTRL_RST 6'h00
`define PSE_THRESH_RST 16'h0000
`define PSE_COUNT_RST 32'h0000_0000
`define PSE_SHADOW_RST 8'h0A
// Delay from overflow to history freeze, cycles
`define PSE_FREEZE_DLY 4'h4
// Source flag bit positions from the memory hierarchy
`define PSE_SF_L1 0
`define PSE_SF_FB 1
`define PSE_SF_L2 2
`define PSE_SF_LLC 3
`define PSE_SF_SNOOP 4
`define PSE_SF_MOD 5
`define PSE_SF_FWD 6
`define PSE_SF_DRAM 7
`define PSE_SF_REMOTE 8
`define PSE_SF_EXCL 9
`define PSE_SF_IO 10
`define PSE_SF_UC 11
`define PSE_SF_W 12
// Data-source codes
`define PSE_DS_UNKNOWN 4'h0
`define PSE_DS_L1 4'h1
`define PSE_DS_FILLBUF 4'h2
`define PSE_DS_MID 4'h3
`define PSE_DS_LLC 4'h4
`define PSE_DS_SNP_CLEAN 4'h5
`define PSE_DS_SNP_MOD 4'h6
`define PSE_DS_FWD 4'h8
`define PSE_DS_LOC_SHR 4'hA
`define PSE_DS_REM_SHR 4'hB
`define PSE_DS_LOC_EXC 4'hC
`define PSE_DS_REM_EXC 4'hD
`define PSE_DS_IO 4'hE
`define PSE_DS_UNCACHED 4'hF
// Record layout
`define PSE_REC_WORDS 2'h3
`define PSE_REC_KIND_BIT 31
`endif

/* File: inc/pse_pkg.sv */
// Types shared by the precise sample engine modules
package pse_pkg;
	// Sampler sequence, one-hot
	typedef enum logic [3:0] {
		ST_COUNT = 4'h1,
		ST_SHADOW = 4'h2,
		ST_ARMED = 4'h4,
		ST_WRITE = 4'h8
	} pse_state_type;
	// Four-bit data-source code
	typedef logic [3:0] pse_src_type;
endpackage : pse_pkg

/* File: inc/pse_mem_if.sv */
// Record memory port bundle between sampler and record store
interface pse_mem_if;
	logic we; // Write strobe
	logic [3:0] waddr; // Write word address
	logic [31:0] wdata; // Write data
	logic [3:0] raddr; // Read word address
	logic [31:0] rdata; // Registered read data
	modport writer(output we, output waddr, output wdata, output raddr, input rdata);
	modport store(input we, input waddr, input wdata, input raddr, output rdata);
endinterface : pse_mem_if

/* File: hdl/pse_record_mem.sv */
// Sixteen-word record store with registered read data
module pse_record_mem (
	input wire logic clk_i,
	input wire logic rst_i,
	pse_mem_if.store mem
);
	logic [31:0] words_q [16]; // Record words

	// Write port, cleared at reset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < 16; i++) begin
				words_q[i] <= 32'h0000_0000;
			end
		end else if (mem.we) begin
			words_q[mem.waddr] <= mem.wdata;
		end
	end

	// Read port, one cycle latency
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mem.rdata <= 32'h0000_0000;
		end else begin
			mem.rdata <= words_q[mem.raddr];
		end
	end
endmodule // pse_record_mem

/* File: hdl/pse_sampler.sv */
// Precise sample engine: event counter, shadow arming, record writer and register slave
`include "pse_params.svh"
// Overview of operation
// - Codes 0..3: unknown miss, L1, fill buffer, mid
// - Code 4: last-level hit without snoop
// - Snooped hit: 5 clean, 6 modified copy
// - Forwarded local miss is 8; never 7, 9
// - Memory fills coded A to D
// - Code E for I/O, F uncacheable
// - Source code in low four field bits
// - Three record words plus monitor interrupt
// - Count retired or mispredicted branches by type
// - Branch record holds branch target pointer
// - Taken: the branch's own target; else next instruction
// - Events during shadow never sampled
// - History freezes after delay following overflow
// - Count loads whose latency exceeds threshold
// - Overflow starts the shadow, then arms; next qualifying load recorded
// - Armed sampler captures next event, then disarms
module pse_sampler (
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone classic slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [31:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Load pipeline
	input wire logic ld_exec_i,
	input wire logic [31:0] ld_exec_addr_i,
	input wire logic ld_ret_i,
	input wire logic [15:0] ld_latency_i,
	input wire logic [11:0] ld_src_flags_i,
	// Branch retirement
	input wire logic br_ret_i,
	input wire logic br_call_i,
	input wire logic br_cond_i,
	input wire logic br_taken_i,
	input wire logic br_mispred_i,
	input wire logic [31:0] br_target_i,
	input wire logic [31:0] br_next_ip_i,
	// Status toward software and history
	output logic monitor_interrupt_o,
	output logic hist_frozen_o,
	output logic [31:0] hist_newest_o,
	output pse_pkg::pse_src_type last_src_o
);
	import pse_pkg::*;

	// Classify the hierarchy flags into a data-source code
	function automatic pse_src_type src_code(input logic [11:0] f);
		pse_src_type c;
		c = `PSE_DS_UNKNOWN;
		if (f[`PSE_SF_UC]) begin
			c = `PSE_DS_UNCACHED;
		end else if (f[`PSE_SF_IO]) begin
			c = `PSE_DS_IO;
		end else if (f[`PSE_SF_L1]) begin
			c = `PSE_DS_L1;
		end else if (f[`PSE_SF_FB]) begin
			c = `PSE_DS_FILLBUF;
		end else if (f[`PSE_SF_L2]) begin
			c = `PSE_DS_MID;
		end else if (f[`PSE_SF_LLC]) begin
			// Snooped hits split by modified copy
			if (!f[`PSE_SF_SNOOP]) begin
				c = `PSE_DS_LLC;
			end else if (f[`PSE_SF_MOD]) begin
				c = `PSE_DS_SNP_MOD;
			end else begin
				c = `PSE_DS_SNP_CLEAN;
			end
		end else if (f[`PSE_SF_FWD] && !f[`PSE_SF_REMOTE]) begin
			c = `PSE_DS_FWD;
		end else if (f[`PSE_SF_DRAM]) begin
			// Memory fills by home and state
			case ({f[`PSE_SF_EXCL], f[`PSE_SF_REMOTE]})
				2'b00: c = `PSE_DS_LOC_SHR;
				2'b01: c = `PSE_DS_REM_SHR;
				2'b10: c = `PSE_DS_LOC_EXC;
				default: c = `PSE_DS_REM_EXC;
			endcase
		end
		return c;
	endfunction

	// Merge write data into a register under byte enables
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		return r;
	endfunction

	// Bus handshake state
	logic req; // Cycle and strobe both high
	logic wait_q; // First cycle of an access seen
	logic ack_q; // Registered acknowledge
	logic acc; // Access completes at this edge
	logic wr; // Register write at this edge
	logic [7:0] off; // Byte offset within the map
	logic hi_zero; // Upper address bits clear
	logic rec_sel; // Record window selected

	// Software-visible registers
	logic [`PSE_CTRL_W-1:0] ctrl_q; // Enables and branch selection
	logic [15:0] thresh_q; // Load latency limit
	logic [31:0] count_q; // Event counter
	logic [7:0] shadow_len_q; // Shadow length in cycles
	logic [7:0] total_q; // Records written, wrapping

	// Sampler state
	pse_state_type state_q; // Sequence state
	logic [7:0] shd_cnt_q; // Shadow countdown
	logic [1:0] step_q; // Record word being written
	logic [1:0] slot_q; // Next record slot
	logic [31:0] rec_w0_q; // Kind and latency
	logic [31:0] rec_w1_q; // Address or pointer
	logic [31:0] rec_w2_q; // Data-source field
	logic irq_q; // Monitor interrupt pulse

	// Load address and branch history
	logic [31:0] ld_addr_q; // Address latched at execute
	logic [3:0] frz_cnt_q; // Freeze countdown
	logic frozen_q; // History frozen
	logic [31:0] newest_q; // Newest taken target
	pse_src_type last_src_q; // Last recorded source

	// Event qualification
	logic ld_evt; // Load above threshold
	logic br_type_ok; // Branch matches selected type
	logic br_evt; // Qualifying branch
	logic evt; // Any qualifying event
	logic ovf; // Counter wraps this cycle
	logic frz_clr; // Software clears freeze
	logic [31:0] br_ip; // Pointer a branch sample holds

	pse_mem_if mem_bus ();

	// Record store
	pse_record_mem u_mem (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.mem(mem_bus.store)
	);

	// Decode of the bus request
	assign req = wb_cyc_i & wb_stb_i;
	assign acc = req & wait_q & ~ack_q;
	assign wr = acc & wb_we_i;
	assign off = wb_adr_i[7:0];
	assign hi_zero = (wb_adr_i[31:7] == 25'h0000000);
	assign rec_sel = hi_zero & wb_adr_i[`PSE_OFF_REC_BIT];
	assign wb_ack_o = ack_q;
	assign frz_clr = wr && hi_zero && (off == `PSE_OFF_STATUS) && wb_sel_i[0] && wb_dat_i[`PSE_ST_FROZEN];

	// Load qualifies on latency above the limit
	assign ld_evt = ld_ret_i & ctrl_q[`PSE_CTRL_LD_EN] & (ld_latency_i > thresh_q);

	// Branch type filter
	always_comb begin
		case (ctrl_q[`PSE_CTRL_TYPE_LO +: 2])
			`PSE_BT_CALL: br_type_ok = br_call_i;
			`PSE_BT_COND: br_type_ok = br_cond_i;
			default: br_type_ok = 1'b1;
		endcase
	end

	// Retired or retired-mispredicted branches
	assign br_evt = br_ret_i & ctrl_q[`PSE_CTRL_BR_EN] & br_type_ok &
		(~ctrl_q[`PSE_CTRL_MISP] | br_mispred_i);
	assign evt = ld_evt | br_evt;
	assign ovf = evt & (count_q == 32'hFFFF_FFFF);

	// Target when taken, next instruction when not
	assign br_ip = br_taken_i ? br_target_i : br_next_ip_i;

	// Record memory write and read ports
	assign mem_bus.we = (state_q == ST_WRITE);
	assign mem_bus.waddr = {slot_q, step_q};
	assign mem_bus.wdata = (step_q == 2'h0) ? rec_w0_q : (step_q == 2'h1) ? rec_w1_q : rec_w2_q;
	assign mem_bus.raddr = wb_adr_i[5:2];

	// Outputs from registers
	assign monitor_interrupt_o = irq_q;
	assign hist_frozen_o = frozen_q;
	assign hist_newest_o = newest_q;
	assign last_src_o = last_src_q;

	// Two-phase handshake: ack in the cycle after the second
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wait_q <= 1'b0;
			ack_q <= 1'b0;
		end else begin
			wait_q <= req & ~wait_q & ~ack_q;
			ack_q <= acc;
		end
	end

	// Read data mux, unmapped reads zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (acc) begin
			if (rec_sel) begin
				wb_dat_o <= mem_bus.rdata;
			end else if (!hi_zero) begin
				wb_dat_o <= 32'h0000_0000;
			end else begin
				case (off)
					`PSE_OFF_CTRL: wb_dat_o <= {26'h0000000, ctrl_q};
					`PSE_OFF_THRESH: wb_dat_o <= {16'h0000, thresh_q};
					`PSE_OFF_COUNT: wb_dat_o <= count_q;
					`PSE_OFF_SHADOW: wb_dat_o <= {24'h000000, shadow_len_q};
					`PSE_OFF_STATUS: wb_dat_o <= {8'h00, total_q, 6'h00, slot_q, 4'h0,
						state_q == ST_WRITE, frozen_q, state_q == ST_SHADOW, state_q == ST_ARMED};
					`PSE_OFF_NEWEST: wb_dat_o <= newest_q;
					default: wb_dat_o <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Control, threshold and shadow length writes
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_q <= `PSE_CTRL_RST;
			thresh_q <= `PSE_THRESH_RST;
			shadow_len_q <= `PSE_SHADOW_RST;
		end else if (wr && hi_zero) begin
			case (off)
				`PSE_OFF_CTRL: ctrl_q <= 6'(merge({26'h0000000, ctrl_q}, wb_dat_i, wb_sel_i));
				`PSE_OFF_THRESH: thresh_q <= 16'(merge({16'h0000, thresh_q}, wb_dat_i, wb_sel_i));
				`PSE_OFF_SHADOW: shadow_len_q <= 8'(merge({24'h000000, shadow_len_q}, wb_dat_i, wb_sel_i));
				default: ctrl_q <= ctrl_q;
			endcase
		end
	end

	// Event counter; a software write wins over counting
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			count_q <= `PSE_COUNT_RST;
		end else if (wr && hi_zero && off == `PSE_OFF_COUNT) begin
			count_q <= merge(count_q, wb_dat_i, wb_sel_i);
		end else if (evt) begin
			count_q <= count_q + 32'h0000_0001;
		end
	end

	// Load address held from execute, not from retirement
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ld_addr_q <= 32'h0000_0000;
		end else if (ld_exec_i) begin
			ld_addr_q <= ld_exec_addr_i;
		end
	end

	// Sampling sequence: count, shadow, armed, write record
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= ST_COUNT;
			shd_cnt_q <= 8'h00;
			step_q <= 2'h0;
			rec_w0_q <= 32'h0000_0000;
			rec_w1_q <= 32'h0000_0000;
			rec_w2_q <= 32'h0000_0000;
		end else begin
			case (state_q)
				// Overflow starts the shadow
				ST_COUNT: begin
					if (ovf) begin
						state_q <= ST_SHADOW;
						shd_cnt_q <= shadow_len_q;
					end
				end
				// Events here are still counted but not sampled
				ST_SHADOW: begin
					if (shd_cnt_q <= 8'h01) begin
						state_q <= ST_ARMED;
					end else begin
						shd_cnt_q <= shd_cnt_q - 8'h01;
					end
				end
				// Next qualifying event is captured; loads win a tie
				ST_ARMED: begin
					if (ld_evt) begin
						state_q <= ST_WRITE;
						step_q <= 2'h0;
						rec_w0_q <= {16'h0000, ld_latency_i};
						rec_w1_q <= ld_addr_q;
						rec_w2_q <= {28'h0000000, src_code(ld_src_flags_i)};
					end else if (br_evt) begin
						state_q <= ST_WRITE;
						step_q <= 2'h0;
						rec_w0_q <= 32'h8000_0000;
						rec_w1_q <= br_ip;
						rec_w2_q <= 32'h0000_0000;
					end
				end
				// Three words, one per cycle, then disarm
				ST_WRITE: begin
					if (step_q == `PSE_REC_WORDS - 2'h1) begin
						state_q <= ST_COUNT;
						step_q <= 2'h0;
					end else begin
						step_q <= step_q + 2'h1;
					end
				end
				default: state_q <= ST_COUNT;
			endcase
		end
	end

	// Slot advance, record total, source and interrupt pulse
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			slot_q <= 2'h0;
			total_q <= 8'h00;
			irq_q <= 1'b0;
			last_src_q <= `PSE_DS_UNKNOWN;
		end else begin
			irq_q <= 1'b0;
			if (state_q == ST_WRITE && step_q == `PSE_REC_WORDS - 2'h1) begin
				slot_q <= slot_q + 2'h1;
				total_q <= total_q + 8'h01;
				irq_q <= 1'b1;
				last_src_q <= rec_w2_q[3:0];
			end
		end
	end

	// History freeze after a delay; freeze set wins over clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			frz_cnt_q <= 4'h0;
			frozen_q <= 1'b0;
		end else begin
			if (ovf) begin
				frz_cnt_q <= `PSE_FREEZE_DLY;
			end else if (frz_cnt_q != 4'h0) begin
				frz_cnt_q <= frz_cnt_q - 4'h1;
			end
			if (frz_cnt_q == 4'h1) begin
				frozen_q <= 1'b1;
			end else if (frz_clr) begin
				frozen_q <= 1'b0;
			end
		end
	end

	// Newest taken target; branches still enter until the freeze lands
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			newest_q <= 32'h0000_0000;
		end else if (br_ret_i && br_taken_i && !frozen_q) begin
			newest_q <= br_target_i;
		end
	end
endmodule // pse_sampler

/* File: tb/pse_sampler_properties.sv */
// Port-level checks on the precise sample engine
module pse_sampler_properties (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic br_ret_i,
	input wire logic br_taken_i,
	input wire logic [31:0] br_target_i,
	input wire logic monitor_interrupt_o,
	input wire logic hist_frozen_o,
	input wire logic [31:0] hist_newest_o,
	input wire pse_pkg::pse_src_type last_src_o
);
	timeunit 1ns;
	timeprecision 1ps;
	import pse_pkg::*;
	// One domain, reset masks all
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	ack_delay_a: assert property ($rose(wb_cyc_i && wb_stb_i) |=> !wb_ack_o ##1 wb_ack_o)
		else $error("bus answer not two cycles after request");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("bus answer longer than one cycle");
	irq_pulse_a: assert property (monitor_interrupt_o |=> !monitor_interrupt_o)
		else $error("record pulse longer than one cycle");
	irq_gap_a: assert property ($fell(monitor_interrupt_o) |-> !monitor_interrupt_o [*3])
		else $error("second record without new arming");
	no_reserved_a: assert property (last_src_o != 4'h7 && last_src_o != 4'h9)
		else $error("reserved source code produced");
	newest_follow_a: assert property (br_ret_i && br_taken_i && !hist_frozen_o ##1 !hist_frozen_o
		|-> hist_newest_o == $past(br_target_i))
		else $error("newest target not the taken branch target");
	newest_quiet_a: assert property (!(br_ret_i && br_taken_i) |=> $stable(hist_newest_o))
		else $error("newest target moved without a taken branch");
	newest_hold_a: assert property (hist_frozen_o && $past(hist_frozen_o) |-> $stable(hist_newest_o))
		else $error("history moved while frozen");
	freeze_hold_a: assert property (hist_frozen_o && !wb_cyc_i |=> hist_frozen_o)
		else $error("freeze dropped without software clear");
	// Main scenarios reached
	cover property (monitor_interrupt_o);
	cover property ($rose(hist_frozen_o));
	cover property (br_ret_i && br_taken_i && !hist_frozen_o);
endmodule // pse_sampler_properties

bind pse_sampler pse_sampler_properties u_pse_sampler_properties (
	.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
	.br_ret_i(br_ret_i), .br_taken_i(br_taken_i), .br_target_i(br_target_i),
	.monitor_interrupt_o(monitor_interrupt_o), .hist_frozen_o(hist_frozen_o),
	.hist_newest_o(hist_newest_o), .last_src_o(last_src_o)
);

/* File: tb/pse_core_model.sv */
// Core pipeline stand-in driving retired loads and branches
module pse_core_model (
	input wire logic clk_i,
	output logic ld_exec_o,
	output logic [31:0] ld_addr_o,
	output logic ld_ret_o,
	output logic [15:0] ld_lat_o,
	output logic [11:0] ld_flags_o,
	output logic br_ret_o,
	output logic br_call_o,
	output logic br_cond_o,
	output logic br_taken_o,
	output logic br_misp_o,
	output logic [31:0] br_tgt_o,
	output logic [31:0] br_next_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Idle at time zero
	initial {ld_exec_o, ld_addr_o, ld_ret_o, ld_lat_o, ld_flags_o, br_ret_o, br_call_o, br_cond_o,
		br_taken_o, br_misp_o, br_tgt_o, br_next_o} = '0;
	// Load executes, retires next edge; stale values inverted after
	task automatic load(input logic [31:0] a, input logic [15:0] l, input logic [11:0] f);
		ld_exec_o <= 1'b1;
		ld_addr_o <= a;
		@(posedge clk_i);
		ld_exec_o <= 1'b0;
		ld_addr_o <= ~a;
		ld_ret_o <= 1'b1;
		ld_lat_o <= l;
		ld_flags_o <= f;
		@(posedge clk_i);
		ld_ret_o <= 1'b0;
		ld_lat_o <= ~l;
		ld_flags_o <= ~f;
	endtask
	// Branch retire pulse; q is call, cond, taken, mispredicted
	task automatic branch(input logic [3:0] q, input logic [31:0] t, input logic [31:0] n);
		br_ret_o <= 1'b1;
		{br_call_o, br_cond_o, br_taken_o, br_misp_o} <= q;
		br_tgt_o <= t;
		br_next_o <= n;
		@(posedge clk_i);
		br_ret_o <= 1'b0;
		{br_call_o, br_cond_o, br_taken_o, br_misp_o} <= ~q;
		br_tgt_o <= ~t;
		br_next_o <= ~n;
	endtask
endmodule // pse_core_model

/* File: tb/test_pse_sampler.sv */
// Self-checking bench for the precise sample engine
module test_pse_sampler;
	timeunit 1ns;
	timeprecision 1ps;
	import pse_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic req = 1'b0; // Drives cyc and stb together
	logic wb_we = 1'b0;
	logic [31:0] wb_adr = 32'h0, wb_dat = 32'h0, r, a, t, nx, wb_dat_o, hist_newest_o, ld_addr, br_tgt, br_next;
	logic wb_ack_o, monitor_interrupt_o, hist_frozen_o, ld_exec, ld_ret;
	logic br_ret, br_call, br_cond, br_taken, br_misp;
	logic [15:0] lat, ld_lat;
	logic [11:0] ld_flags;
	logic [3:0] e;
	logic [7:0] nrec = 8'h0; // Records written so far
	pse_src_type last_src_o;
	int seed = 32'h33C3CE97;
	int errors = 0;
	int check_count = 0;
	logic [11:0] flags_tbl [16] = '{12'h800, 12'h400, 12'h001, 12'h002, 12'h004, 12'h008, 12'h018,
		12'h038, 12'h040, 12'h080, 12'h180, 12'h280, 12'h380, 12'h000, 12'h140, 12'h801};
	always #2 clk_i = ~clk_i;
	pse_sampler u_pse_sampler (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(wb_we),
		.wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.ld_exec_i(ld_exec), .ld_exec_addr_i(ld_addr), .ld_ret_i(ld_ret), .ld_latency_i(ld_lat),
		.ld_src_flags_i(ld_flags), .br_ret_i(br_ret), .br_call_i(br_call), .br_cond_i(br_cond),
		.br_taken_i(br_taken), .br_mispred_i(br_misp), .br_target_i(br_tgt), .br_next_ip_i(br_next),
		.monitor_interrupt_o(monitor_interrupt_o), .hist_frozen_o(hist_frozen_o),
		.hist_newest_o(hist_newest_o), .last_src_o(last_src_o));
	pse_core_model u_pse_core_model (.clk_i(clk_i), .ld_exec_o(ld_exec), .ld_addr_o(ld_addr),
		.ld_ret_o(ld_ret), .ld_lat_o(ld_lat), .ld_flags_o(ld_flags), .br_ret_o(br_ret), .br_call_o(br_call),
		.br_cond_o(br_cond), .br_taken_o(br_taken), .br_misp_o(br_misp), .br_tgt_o(br_tgt), .br_next_o(br_next));
	// Verdict and end of run
	task automatic complete_run();
		if (errors == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// One classic bus cycle, entered just after a rising edge
	task automatic wb(input logic w, input logic [31:0] ad, input logic [31:0] d);
		int n;
		n = 0;
		req <= 1'b1;
		wb_we <= w;
		wb_adr <= ad;
		wb_dat <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		r = wb_dat_o;
		req <= 1'b0;
		chk({31'h0, wb_ack_o}, 32'h1);
		@(posedge clk_i);
	endtask
	// Wait for the record-complete pulse
	task automatic wait_irq();
		int n;
		for (n = 0; n < 20 && monitor_interrupt_o !== 1'b1; n++)
			@(posedge clk_i);
		chk({31'h0, monitor_interrupt_o}, 32'h1);
	endtask
	// Expected source code by hierarchy priority
	function automatic logic [3:0] exp_src(input logic [11:0] f);
		if (f[11]) return 4'hF;
		if (f[10]) return 4'hE;
		if (f[0]) return 4'h1;
		if (f[1]) return 4'h2;
		if (f[2]) return 4'h3;
		if (f[3]) return f[4] ? (f[5] ? 4'h6 : 4'h5) : 4'h4;
		if (f[6] && !f[8]) return 4'h8;
		if (f[7]) return 4'hA + {2'h0, f[9], f[8]};
		return 4'h0;
	endfunction
	// Address of word k of the current slot
	function automatic logic [31:0] rec(input logic [1:0] k);
		return 32'h40 + {26'h0, nrec[1:0], 4'h0} + {28'h0, k, 2'h0};
	endfunction
	// Main sequence
	initial begin
		int i;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		wb(1'b0, 32'h0C, 32'h0);
		chk(r, 32'h0A);
		wb(1'b1, 32'h24, 32'hFFFF);
		wb(1'b0, 32'h24, 32'h0);
		chk(r, 32'h0);
		wb(1'b1, 32'h00, 32'h1);
		wb(1'b1, 32'h04, 32'h10);
		wb(1'b1, 32'h0C, 32'h08);
		wb(1'b1, 32'h08, 32'hFFFFFFFF);
		u_pse_core_model.load(32'h0, 16'h0010, 12'h0);
		wb(1'b0, 32'h08, 32'h0);
		chk(r, 32'hFFFFFFFF);
		u_pse_core_model.load(32'h0, 16'h0011, 12'h0);
		wb(1'b0, 32'h08, 32'h0);
		chk(r, 32'h0);
		repeat (10) @(posedge clk_i);
		for (i = 0; i < 16; i++) begin
			a = $random(seed);
			lat = 16'h0011 + {8'h0, 8'($random(seed))};
			e = exp_src(flags_tbl[i]);
			u_pse_core_model.load(a, lat, flags_tbl[i]);
			wait_irq();
			chk({28'h0, last_src_o}, {28'h0, e});
			wb(1'b0, rec(2'h0), 32'h0);
			chk(r, {16'h0, lat});
			wb(1'b0, rec(2'h1), 32'h0);
			chk(r, a);
			wb(1'b0, rec(2'h2), 32'h0);
			chk(r, {28'h0, e});
			nrec++;
			if (i < 15) begin
				wb(1'b1, 32'h08, 32'hFFFFFFFF);
				u_pse_core_model.load(~a, lat, 12'h001);
				u_pse_core_model.load(a ^ 32'h5A5A5A5A, lat, 12'h800);
				repeat (10) @(posedge clk_i);
			end
		end
		for (i = 0; i < 3; i++) begin
			t = $random(seed);
			nx = $random(seed);
			wb(1'b1, 32'h00, {26'h0, i[1:0], 1'b0, i == 0, 1'b1, 1'b0});
			wb(1'b1, 32'h08, 32'hFFFFFFFF);
			u_pse_core_model.branch({i == 1, i == 2, 2'h3}, ~t, nx);
			repeat (10) @(posedge clk_i);
			chk({31'h0, hist_frozen_o}, 32'h1);
			wb(1'b1, 32'h10, 32'h4);
			chk({31'h0, hist_frozen_o}, 32'h0);
			u_pse_core_model.branch({i == 2, i == 1, 1'b1, i != 0}, ~nx, t);
			@(posedge clk_i);
			u_pse_core_model.branch({i == 1, i == 2, i != 2, 1'b1}, t, nx);
			wait_irq();
			wb(1'b0, rec(2'h0), 32'h0);
			chk({31'h0, r[31]}, 32'h1);
			wb(1'b0, rec(2'h1), 32'h0);
			chk(r, (i != 2) ? t : nx);
			if (i != 2)
				chk(hist_newest_o, t);
			nrec++;
		end
		wb(1'b0, 32'h10, 32'h0);
		chk({24'h0, r[23:16]}, {24'h0, nrec});
		complete_run();
	end
	// Cut a hung run short
	initial begin
		repeat (20000) @(posedge clk_i);
		errors++;
		complete_run();
	end
endmodule // test_pse_sampler
